// ===== logic/ceig_consts.svh
// Notes on behaviour
// - user card fault or presence sets bit 7
// - first module faults set bit 6
// - second module faults set bit 5
// - third module faults set bit 4
// - over-temperature shutdown sets bit 3
// - supervisor fault shutdown sets bit 2
// - sync activation done sets bit 1
// - any input pin change sets bit 0
// - summary resets zero, clears on read
// - settings bit 7 boost enable, resets 1
// - settings bits 5:2 pin direction, 1=input
// - level bits 7:4 show sampled pin levels
// - level bits 3:0 drive outputs, reset 1
// - user mask bits 7:5 premature, mute, overcurrent
// - user mask bits 4:0 sync, thermal, supervisor, pins, presence
// - module mask bits 7:5 first, 4:2 second
// - bit 1 modules supply, bit 0 user supply
// - third mask bits 7:5 premature, mute, overcurrent
// - third mask bits 4:1 mask pin changes
// - premature early answer, mute no answer
// - card flags clear on own status read
`ifndef CEIG_CONSTS_SVH
`define CEIG_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CEIG_OFF_REVISION 8'h40
`define CEIG_OFF_SUMMARY 8'h41
`define CEIG_OFF_SETTINGS 8'h42
`define CEIG_OFF_LEVELS 8'h43
`define CEIG_OFF_UC_MASK 8'h44
`define CEIG_OFF_M12_MASK 8'h45
`define CEIG_OFF_M3_MASK 8'h46

// ----------------------------------------
// field positions
// ----------------------------------------
`define CEIG_SUM_UC 7
`define CEIG_SUM_MOD_TOP 6
`define CEIG_SUM_THERM 3
`define CEIG_SUM_SUPL 2
`define CEIG_SUM_SYNC 1
`define CEIG_SUM_PINS 0
`define CEIG_SET_BOOST 7
`define CEIG_SET_DIR_LO 2
`define CEIG_LVL_IN_LO 4
`define CEIG_UCM_PREM 7
`define CEIG_UCM_MUTE 6
`define CEIG_UCM_OC 5
`define CEIG_UCM_SYNC 4
`define CEIG_UCM_THERM 3
`define CEIG_UCM_SUPL 2
`define CEIG_UCM_PINS 1
`define CEIG_UCM_PRES 0
`define CEIG_M12_MOD_SUPPLY 1
`define CEIG_M12_UC_SUPPLY 0
`define CEIG_M3_PIN_LO 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define CEIG_RST_SUMMARY 8'h00
`define CEIG_RST_SETTINGS 8'h80
`define CEIG_RST_OUT_LEVELS 4'hf
`define CEIG_RST_MASK 8'h00
`define CEIG_RST_REVISION 8'h5a

`endif

// ===== logic/ceig_pkg.sv
package ceig_pkg;
    // per-module fault set: premature, mute, overcurrent, supply ramp
    typedef struct packed {
        logic premature;
        logic mute;
        logic overcurrent;
        logic supply;
    } ceig_fault_t;
    typedef logic [7:0] ceig_byte_t;
endpackage

// ===== logic/ceig_regs.sv
`timescale 1ns/100ps
`include "ceig_consts.svh"

module ceig_regs
#(
    // arbitrary neutral value, not a real part code
    parameter logic [7:0] REVISION = `CEIG_RST_REVISION
)
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire ceig_pkg::ceig_fault_t user_fault_evt,
    input wire logic presence_change_flag,
    input wire ceig_pkg::ceig_fault_t [2:0] secure_module_evt,
    input wire logic thermal_evt,
    input wire logic supervisor_evt,
    input wire logic sync_done_evt,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_n,
    output logic boost_enable,
    output logic attention_n
);

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    logic [7:0] summary_ff, nxt_summary;
    logic [7:0] settings_ff, nxt_settings;
    logic [3:0] out_levels_ff, nxt_out_levels;
    logic [7:0] uc_mask_ff, nxt_uc_mask;
    logic [7:0] m12_mask_ff, nxt_m12_mask;
    logic [7:0] m3_mask_ff, nxt_m3_mask;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [3:0] pin_meta_ff, pin_sync_ff, pin_prev_ff;
    logic [3:0] nxt_pin_meta, nxt_pin_sync, nxt_pin_prev;
    logic [3:0] pin_dir;
    logic [3:0] pin_change;
    logic [7:0] set_req;
    logic [2:0] mod_raise;
    logic uc_raise;
    logic pins_raise;
    logic sum_read;

    assign pin_dir = settings_ff[`CEIG_SET_DIR_LO +: 4];
    assign sum_read = reg_rd && hit(reg_addr, `CEIG_OFF_SUMMARY);

    // ----------------------------------------
    // pin sampling and change detection
    // ----------------------------------------
    // two stages before any logic reads the pin; compare takes the second stage and a third that delays it
    always_comb
    begin
        nxt_pin_meta = pin_in;
        nxt_pin_sync = pin_meta_ff;
        nxt_pin_prev = pin_sync_ff;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            pin_meta_ff <= 4'h0;
            pin_sync_ff <= 4'h0;
            pin_prev_ff <= 4'h0;
        end
        else
        begin
            pin_meta_ff <= nxt_pin_meta;
            pin_sync_ff <= nxt_pin_sync;
            pin_prev_ff <= nxt_pin_prev;
        end
    end

    // only pins set as inputs report, each behind its own mask
    assign pin_change = (pin_sync_ff ^ pin_prev_ff) & pin_dir
        & ~m3_mask_ff[`CEIG_M3_PIN_LO +: 4];
    assign pins_raise = |pin_change && !uc_mask_ff[`CEIG_UCM_PINS];

    // ----------------------------------------
    // source gating
    // ----------------------------------------
    // card event inputs are one-cycle pulses of flags that their own status
    // registers keep and clear; this block never clears them itself
    // premature means answer before window, mute means none inside it
    assign uc_raise =
        (user_fault_evt.premature && !uc_mask_ff[`CEIG_UCM_PREM])
        || (user_fault_evt.mute && !uc_mask_ff[`CEIG_UCM_MUTE])
        || (user_fault_evt.overcurrent && !uc_mask_ff[`CEIG_UCM_OC])
        || (user_fault_evt.supply && !m12_mask_ff[`CEIG_M12_UC_SUPPLY])
        || (presence_change_flag && !uc_mask_ff[`CEIG_UCM_PRES]);

    // per-module masks: first 0x45[7:5], second 0x45[4:2], third 0x46[7:5]
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_mod
            logic [2:0] mmask;
            assign mmask = (gi == 0) ? m12_mask_ff[7:5] :
                           (gi == 1) ? m12_mask_ff[4:2] : m3_mask_ff[7:5];
            assign mod_raise[gi] =
                (secure_module_evt[gi].premature && !mmask[2])
                || (secure_module_evt[gi].mute && !mmask[1])
                || (secure_module_evt[gi].overcurrent && !mmask[0])
                || (secure_module_evt[gi].supply
                    && !m12_mask_ff[`CEIG_M12_MOD_SUPPLY]);
        end
    endgenerate

    // ----------------------------------------
    // event summary
    // ----------------------------------------
    // masked events never reach the summary, so the active-low line is just its NOR
    always_comb
    begin
        set_req = 8'h00;
        set_req[`CEIG_SUM_UC] = uc_raise;
        // first module owns the top bit, so the order is flipped here
        set_req[`CEIG_SUM_MOD_TOP -: 3] = {mod_raise[0], mod_raise[1], mod_raise[2]};
        set_req[`CEIG_SUM_THERM] = thermal_evt && !uc_mask_ff[`CEIG_UCM_THERM];
        set_req[`CEIG_SUM_SUPL] = supervisor_evt && !uc_mask_ff[`CEIG_UCM_SUPL];
        set_req[`CEIG_SUM_SYNC] = sync_done_evt && !uc_mask_ff[`CEIG_UCM_SYNC];
        set_req[`CEIG_SUM_PINS] = pins_raise;
        // a set in the read cycle survives, so no event is lost
        nxt_summary = (sum_read ? 8'h00 : summary_ff) | set_req;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            summary_ff <= `CEIG_RST_SUMMARY;
        else
            summary_ff <= nxt_summary;
    end

    assign attention_n = ~|summary_ff;

    // ----------------------------------------
    // writable settings and masks
    // ----------------------------------------
    always_comb
    begin
        nxt_settings = settings_ff;
        nxt_out_levels = out_levels_ff;
        nxt_uc_mask = uc_mask_ff;
        nxt_m12_mask = m12_mask_ff;
        nxt_m3_mask = m3_mask_ff;
        if (reg_wr)
        begin
            // bits 6, 1 and 0 of settings are unused and stay zero
            if (hit(reg_addr, `CEIG_OFF_SETTINGS))
                nxt_settings = reg_wdata & 8'hbc;
            if (hit(reg_addr, `CEIG_OFF_LEVELS))
                nxt_out_levels = reg_wdata[3:0];
            if (hit(reg_addr, `CEIG_OFF_UC_MASK))
                nxt_uc_mask = reg_wdata;
            if (hit(reg_addr, `CEIG_OFF_M12_MASK))
                nxt_m12_mask = reg_wdata;
            if (hit(reg_addr, `CEIG_OFF_M3_MASK))
                nxt_m3_mask = reg_wdata & 8'hfe;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            settings_ff <= `CEIG_RST_SETTINGS;
            out_levels_ff <= `CEIG_RST_OUT_LEVELS;
            uc_mask_ff <= `CEIG_RST_MASK;
            m12_mask_ff <= `CEIG_RST_MASK;
            m3_mask_ff <= `CEIG_RST_MASK;
        end
        else
        begin
            settings_ff <= nxt_settings;
            out_levels_ff <= nxt_out_levels;
            uc_mask_ff <= nxt_uc_mask;
            m12_mask_ff <= nxt_m12_mask;
            m3_mask_ff <= nxt_m3_mask;
        end
    end

    assign boost_enable = settings_ff[`CEIG_SET_BOOST];
    // an input pin keeps its level bit but does not drive it
    assign pin_out = out_levels_ff;
    assign pin_oe_n = pin_dir;

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // one cycle latency; unmapped offsets read zero
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (reg_rd)
        begin
            if (hit(reg_addr, `CEIG_OFF_REVISION))
                nxt_rdata = REVISION;
            if (hit(reg_addr, `CEIG_OFF_SUMMARY))
                nxt_rdata = summary_ff;
            if (hit(reg_addr, `CEIG_OFF_SETTINGS))
                nxt_rdata = settings_ff;
            if (hit(reg_addr, `CEIG_OFF_LEVELS))
                nxt_rdata = {pin_sync_ff, out_levels_ff};
            if (hit(reg_addr, `CEIG_OFF_UC_MASK))
                nxt_rdata = uc_mask_ff;
            if (hit(reg_addr, `CEIG_OFF_M12_MASK))
                nxt_rdata = m12_mask_ff;
            if (hit(reg_addr, `CEIG_OFF_M3_MASK))
                nxt_rdata = m3_mask_ff;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            rdata_ff <= 8'h00;
        else
            rdata_ff <= nxt_rdata;
    end

    assign reg_rdata = rdata_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_pin_toggle(i);
        pin_dir[i] && !m3_mask_ff[i + 1] && !uc_mask_ff[`CEIG_UCM_PINS]
            && pin_sync_ff[i] != pin_prev_ff[i];
    endsequence

    AST_UC_OC_SETS: assert property (
        user_fault_evt.overcurrent && !uc_mask_ff[`CEIG_UCM_OC]
        |=> summary_ff[`CEIG_SUM_UC] && !attention_n)
        else $error("user overcurrent did not raise summary");
    AST_MOD1_SETS: assert property (
        secure_module_evt[0].mute && !m12_mask_ff[6] |=> summary_ff[6])
        else $error("first module mute did not raise summary");
    AST_MOD2_SETS: assert property (
        secure_module_evt[1].overcurrent && !m12_mask_ff[2] |=> summary_ff[5])
        else $error("second module overcurrent did not raise summary");
    AST_MOD3_SETS: assert property (
        secure_module_evt[2].premature && !m3_mask_ff[7] |=> summary_ff[4])
        else $error("third module premature did not raise summary");
    AST_THERM_SETS: assert property (
        thermal_evt && !uc_mask_ff[3] |=> summary_ff[3] && !attention_n)
        else $error("thermal event lost");
    AST_SUPL_SETS: assert property (
        supervisor_evt && !uc_mask_ff[2] |=> summary_ff[2])
        else $error("supervisor event lost");
    AST_SYNC_SETS: assert property (
        sync_done_evt && !uc_mask_ff[4] |=> summary_ff[1])
        else $error("sync completion lost");
    AST_PIN_CHANGE: assert property (
        s_pin_toggle(0) |=> summary_ff[0])
        else $error("pin change did not raise summary");
    AST_READ_CLEARS: assert property (
        sum_read && set_req == 8'h00 ##1 1'b1 |-> summary_ff == 8'h00
        && reg_rdata == $past(summary_ff))
        else $error("summary read did not return and clear");
    AST_MASKED_QUIET: assert property (
        thermal_evt && uc_mask_ff[`CEIG_UCM_THERM] && summary_ff == 8'h00
        && set_req[7:4] == 4'h0 && set_req[2:0] == 3'h0 |=> attention_n)
        else $error("masked thermal event pulled the line");
    AST_MASKED_SYNC: assert property (
        sync_done_evt && uc_mask_ff[4] && (summary_ff[1] == 1'b0 || sum_read)
        |=> !summary_ff[1])
        else $error("masked sync completion set summary");
    AST_BOOST_WRITE: assert property (
        reg_wr && hit(reg_addr, `CEIG_OFF_SETTINGS)
        |=> boost_enable == $past(reg_wdata[7]) && pin_oe_n == $past(reg_wdata[5:2]))
        else $error("settings write not applied");
    AST_LEVEL_READ: assert property (
        reg_rd && hit(reg_addr, `CEIG_OFF_LEVELS)
        |=> reg_rdata[7:4] == $past(pin_sync_ff) && reg_rdata[3:0] == $past(pin_out))
        else $error("level read mismatch");
    AST_SUM_RESET: assert property (
        disable iff (1'b0) !resetn |=> summary_ff == `CEIG_RST_SUMMARY && attention_n)
        else $error("summary not cleared by reset");
    AST_LEVEL_WRITE: assert property (
        reg_wr && hit(reg_addr, `CEIG_OFF_LEVELS) |=> pin_out == $past(reg_wdata[3:0]))
        else $error("level write not applied");
    AST_MOD_SUPPLY: assert property (
        secure_module_evt[1].supply && !m12_mask_ff[`CEIG_M12_MOD_SUPPLY] |=> summary_ff[5])
        else $error("second module supply fault lost");
    AST_UC_SUPPLY_MASKED: assert property (
        user_fault_evt == 4'h1 && !presence_change_flag && m12_mask_ff[`CEIG_M12_UC_SUPPLY]
        && (!summary_ff[7] || sum_read) |=> !summary_ff[7])
        else $error("masked user supply fault set summary");
    AST_PIN1_MASKED: assert property (
        pin_sync_ff[3:1] == pin_prev_ff[3:1] && m3_mask_ff[`CEIG_M3_PIN_LO]
        && (!summary_ff[0] || sum_read) |=> !summary_ff[0])
        else $error("masked pin change set summary");

endmodule

// ===== bench/ceig_host_model.sv
`timescale 1ns/100ps

module ceig_host_model
(
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // ----------------------------------------
    // host side of the register port
    // ----------------------------------------
    // address lines flip after each access and data lines after each write, so a stale value never looks valid
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // one-cycle write strobe, address and data held with it
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
    endtask

    // read data is registered, so it is taken just after the sampling edge
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~addr;
        #1;
        data = reg_rdata;
    endtask

    // attention service: the summary is read first, which clears it
    task automatic service_summary(output logic [7:0] data);
        reg_read(8'h41, data);
    endtask
endmodule

// ===== bench/card_event_irq_and_gpio_regs_tb.sv
`timescale 1ns/100ps

module card_event_irq_and_gpio_regs_tb;
    localparam logic [7:0] REV = 8'h3c; // arbitrary value
    localparam int LIMIT = 20000;
    localparam logic [7:0] RST_TAB [8] = '{REV, 8'h00, 8'h80, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] RW_MASK [5] = '{8'hbc, 8'h0f, 8'hff, 8'hff, 8'hfe};
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, ucm, m12, m3;
    logic reg_wr, reg_rd, boost_enable, attention_n;
    logic [19:0] ev = 20'h0;
    logic [3:0] pin_in, pin_out, pin_oe_n;
    logic [3:0] pin_drv = 4'hf;
    logic [7:0] wv [5];
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed, k, msk, m;

    // ----------------------------------------
    // clock, pins, instances
    // ----------------------------------------
    always #20 core_clk = ~core_clk;
    // wire level: out of reset the device wins where it drives, far side elsewhere and in reset
    assign pin_in = resetn ? ((~pin_oe_n & pin_out) | (pin_oe_n & pin_drv)) : pin_drv;

    ceig_host_model u_host
    (
        .core_clk(core_clk),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata)
    );

    ceig_regs #(.REVISION(REV)) u_dut
    (
        .core_clk(core_clk),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .user_fault_evt(ev[3:0]),
        .presence_change_flag(ev[4]),
        .secure_module_evt(ev[16:5]),
        .thermal_evt(ev[17]),
        .supervisor_evt(ev[18]),
        .sync_done_evt(ev[19]),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe_n(pin_oe_n),
        .boost_enable(boost_enable),
        .attention_n(attention_n)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // event index i: 0..3 user supply/oc/mute/early, 4 presence,
    // 5..16 modules, 17 thermal, 18 supervisor, 19 sync
    function automatic logic [7:0] exp_sum(input int i);
        int b;
        int f;
        logic mb;
        f = (i - 5) % 4;
        b = (i < 5) ? 7 : (i < 17) ? 6 - (i - 5) / 4 : 20 - i;
        if (i < 4)
            mb = (i == 0) ? m12[0] : ucm[4 + i];
        else if (i == 4)
            mb = ucm[0];
        else if (i < 17)
            mb = (f == 0) ? m12[1] : (i < 9) ? m12[4 + f] : (i < 13) ? m12[1 + f] : m3[4 + f];
        else
            mb = (i == 17) ? ucm[3] : (i == 18) ? ucm[2] : ucm[4];
        return mb ? 8'h00 : 8'h01 << b;
    endfunction

    function automatic logic [7:0] pick(input int p);
        return (p == 0) ? 8'h00 : (p == 1) ? 8'hff : 8'($urandom);
    endfunction

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h0, got}, {7'h0, exp});
    endtask

    task automatic set_masks;
        u_host.reg_write(8'h44, ucm);
        u_host.reg_write(8'h45, m12);
        u_host.reg_write(8'h46, m3);
    endtask

    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // hang guard
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            mismatches++;
            results();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        seed = $urandom(60);
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        #1;
        chk_bit(boost_enable, 1'b1);
        chk_byte({4'h0, pin_oe_n, pin_out}, 8'h0f);
        chk_bit(attention_n, 1'b1);
        // writes to read-only and unmapped places must change nothing
        u_host.reg_write(8'h40, 8'hff);
        u_host.reg_write(8'h41, 8'hff);
        u_host.reg_write(8'h47, 8'hff);
        for (int a = 0; a < 8; a++)
        begin
            u_host.reg_read(8'h40 + 8'(a), d);
            chk_byte(d, RST_TAB[a]);
        end
        for (int a = 0; a < 5; a++)
        begin
            d = 8'($urandom);
            u_host.reg_write(8'h42 + 8'(a), d);
            wv[a] = d & RW_MASK[a];
            repeat (3) @(posedge core_clk);
            u_host.reg_read(8'h42 + 8'(a), d);
            chk_byte(d, wv[a] | ((a == 1) ? {pin_in, 4'h0} : 8'h00));
        end
        chk_bit(boost_enable, wv[0][7]);
        chk_byte({4'h0, pin_oe_n, pin_out}, {4'h0, wv[0][5:2], wv[1][3:0]});
        // every event input with masks clear, set, then random
        u_host.reg_write(8'h42, 8'h80);
        repeat (4) @(posedge core_clk);
        u_host.reg_read(8'h41, d);
        for (int p = 0; p < 3; p++)
            for (int i = 0; i < 20; i++)
            begin
                ucm = pick(p);
                m12 = pick(p);
                m3 = pick(p);
                set_masks();
                @(posedge core_clk);
                ev <= 20'h1 << i;
                @(posedge core_clk);
                ev <= 20'h0;
                #1;
                chk_bit(attention_n, exp_sum(i) == 8'h00);
                u_host.reg_read(8'h41, d);
                chk_byte(d, exp_sum(i));
                chk_bit(attention_n, 1'b1);
            end
        // event landing in the same cycle as the clearing read survives
        ucm = 8'h00;
        m12 = 8'h00;
        m3 = 8'h00;
        set_masks();
        fork
            u_host.reg_read(8'h41, d);
            begin
                @(posedge core_clk);
                ev <= 20'h20000;
                @(posedge core_clk);
                ev <= 20'h0;
            end
        join
        chk_byte(d, 8'h00);
        chk_bit(attention_n, 1'b0);
        u_host.service_summary(d);
        chk_byte(d, 8'h08);
        // pins as inputs: change events, per-pin and global masks
        u_host.reg_write(8'h42, 8'hbc);
        repeat (4) @(posedge core_clk);
        u_host.reg_read(8'h41, d);
        for (int i = 0; i < 12; i++)
        begin
            k = $urandom % 4;
            msk = $urandom % 2;
            m = (i >= 8) ? 1 : 0;
            u_host.reg_write(8'h44, 8'(m << 1));
            u_host.reg_write(8'h46, 8'(msk << (k + 1)));
            pin_drv <= pin_drv ^ (4'h1 << k);
            repeat (5) @(posedge core_clk);
            u_host.reg_read(8'h43, d);
            chk_byte(d, {pin_drv, wv[1][3:0]});
            u_host.reg_read(8'h41, d);
            chk_byte(d, (msk == 1 || m == 1) ? 8'h00 : 8'h01);
        end
        // reset in mid-run: a pending flag and the settings must fall back
        @(posedge core_clk);
        ev <= 20'h40000;
        @(posedge core_clk);
        ev <= 20'h0;
        resetn <= 1'b0;
        #1;
        chk_bit(attention_n, 1'b0);
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        #1;
        chk_bit(attention_n, 1'b1);
        chk_byte({boost_enable, 3'h0, pin_oe_n}, 8'h80);
        u_host.reg_read(8'h41, d);
        chk_byte(d, 8'h00);
        results();
    end
endmodule
